// *** hw/gpx_expander.sv ***
// Overview of operation
// - alert asserts while any input pin differs from its captured snapshot bit.
// - an input pin edge away from its snapshot raises the alert once held for the settle delay.
// - alert clears when pins return to snapshot or input register is read.
// - read clear takes effect at the acknowledge bit after the rising clock.
// - after each clear, later pin changes are detected and reported afresh.
// - traffic for other targets and output pins never touch the alert.
// - switching a pin from output to input may raise a spurious alert.
// - alert is open drain: drives low when asserted, released otherwise.
// - three strap inputs select low address bits, eight devices per bus.
// - reset restores register defaults and idles the bus state machine.
// - after reset every pin is an input with drivers off.
// - polarity register inverts input data per bit; all registers readable.
// - input pins have both drivers off, high impedance.
// - output pins drive high or low from the output latch bit.
// - own address is acknowledged by holding data low over the ack pulse.
// - one bit per clock pulse; data change during clock high is START/STOP.
// - each byte is followed by an ack; device acks every received byte.
// - on read, controller nacks last byte; device then releases data.
// - command byte low two bits select input, output, polarity, direction.
// - address is fixed upper bits plus straps, 20h to 27h; lsb 1 reads.
// - direction 1 is input; direction and output reset ones, polarity zeros.
// - register pointer never increments; repeated reads and writes hit it.
`timescale 1ns/1ps
`default_nettype none
module gpx_expander (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe,
	input  wire logic       addr_strap_bit0,
	input  wire logic       addr_strap_bit1,
	input  wire logic       addr_strap_bit2,
	input  wire logic [7:0] port_pins_in,
	output var  logic [7:0] port_pins_out,
	output var  logic [7:0] port_pins_oe,
	output var  logic [7:0] high_side_driver,
	output var  logic [7:0] low_side_driver,
	output var  logic       alert_n_out,
	output var  logic       alert_n_oe
);
	// ------------------------------------------------------------
	// synchronisers
	// ------------------------------------------------------------
	logic [12:0] sync_q;
	logic        scl_s;
	logic        sda_s;
	logic [2:0]  strap_s;
	logic [7:0]  pins_s;

	gpx_sync #(
		.W (13)
	) u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.d       ({scl_in, sda_in, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
			port_pins_in}),
		.q       (sync_q)
	);

	assign scl_s   = sync_q[12];
	assign sda_s   = sync_q[11];
	assign strap_s = sync_q[10:8];
	assign pins_s  = sync_q[7:0];

	// ------------------------------------------------------------
	// bus condition detection
	// ------------------------------------------------------------
	logic scl_d_reg;
	logic sda_d_reg;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] output_reg;
	logic [7:0] polarity_reg;
	logic [7:0] direction_reg;
	logic [1:0] cmd_reg;
	logic [7:0] snapshot_reg;
	logic [7:0] input_value;

	assign input_value = pins_s ^ polarity_reg;

	// ------------------------------------------------------------
	// serial state machine
	// ------------------------------------------------------------
	gpx_pkg::gpx_state_t state_reg;
	gpx_pkg::gpx_state_t after_ack_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic       ack_drive_reg;
	logic       rd_mode_reg;
	logic       read_clear;
	logic [7:0] read_byte;
	logic       addr_match;
	logic [7:0] wdata_reg;
	logic       wdata_pend_reg;

	assign addr_match = (shift_reg[7:1] == {gpx_pkg::ADDR_FIXED, strap_s});

	always_comb begin
		case (cmd_reg)
			gpx_pkg::CMD_INPUT:     read_byte = input_value;
			gpx_pkg::CMD_OUTPUT:    read_byte = output_reg;
			gpx_pkg::CMD_POLARITY:  read_byte = polarity_reg;
			default:                read_byte = direction_reg;
		endcase
	end

	// clear fires on scl rise of the ack bit after an input register byte
	assign read_clear = (state_reg == gpx_pkg::ST_ACK) & rd_mode_reg & scl_rise &
		(cmd_reg == gpx_pkg::CMD_INPUT) & ~ack_drive_reg;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg     <= gpx_pkg::ST_IDLE;
			after_ack_reg <= gpx_pkg::ST_IDLE;
			bit_cnt_reg   <= 3'h0;
			shift_reg     <= 8'h00;
			ack_drive_reg <= 1'b0;
			rd_mode_reg   <= 1'b0;
			sda_out       <= 1'b0;
			sda_oe        <= 1'b0;
		end else if (start_det) begin
			state_reg   <= gpx_pkg::ST_ADDR;
			bit_cnt_reg <= 3'h0;
			ack_drive_reg <= 1'b1;
			rd_mode_reg <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (stop_det) begin
			state_reg <= gpx_pkg::ST_IDLE;
			sda_oe    <= 1'b0;
		end else begin
			case (state_reg)
				gpx_pkg::ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				gpx_pkg::ST_ADDR, gpx_pkg::ST_CMD, gpx_pkg::ST_WDATA: begin
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
					end
					if (scl_fall && bit_cnt_reg == 3'h0 && ack_drive_reg) begin
						ack_drive_reg <= 1'b0;
					end else if (scl_fall && bit_cnt_reg == 3'h0) begin
						if (state_reg == gpx_pkg::ST_ADDR && !addr_match) begin
							state_reg <= gpx_pkg::ST_IDLE;
						end else begin
							sda_oe  <= 1'b1;
							sda_out <= 1'b0;
							ack_drive_reg <= 1'b1;
							if (state_reg == gpx_pkg::ST_ADDR && shift_reg[0]) begin
								rd_mode_reg   <= 1'b1;
								after_ack_reg <= gpx_pkg::ST_RDATA;
							end else if (state_reg == gpx_pkg::ST_ADDR) begin
								after_ack_reg <= gpx_pkg::ST_CMD;
							end else begin
								after_ack_reg <= gpx_pkg::ST_WDATA;
							end
							state_reg <= gpx_pkg::ST_ACK;
						end
					end
				end
				gpx_pkg::ST_ACK: begin
					if (scl_fall) begin
						sda_oe <= 1'b0;
						if (rd_mode_reg && !ack_drive_reg && scl_d_reg && sda_d_reg) begin
							state_reg <= gpx_pkg::ST_IDLE;
						end else begin
							state_reg   <= after_ack_reg;
							bit_cnt_reg <= 3'h0;
							if (after_ack_reg == gpx_pkg::ST_RDATA) begin
								sda_oe    <= ~read_byte[7];
								sda_out   <= 1'b0;
								shift_reg <= {read_byte[6:0], 1'b1};
								bit_cnt_reg <= 3'h1;
							end
						end
						ack_drive_reg <= 1'b0;
					end
				end
				gpx_pkg::ST_RDATA: begin
					if (scl_fall && bit_cnt_reg == 3'h0) begin
						sda_oe    <= 1'b0;
						state_reg <= gpx_pkg::ST_ACK;
					end else if (scl_fall) begin
						sda_oe      <= ~shift_reg[7];
						shift_reg   <= {shift_reg[6:0], 1'b1};
						bit_cnt_reg <= bit_cnt_reg + 3'h1;
					end
				end
				default: begin
					state_reg <= gpx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	logic byte_done;

	assign byte_done = scl_fall & (bit_cnt_reg == 3'h0) & ~ack_drive_reg;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_reg        <= gpx_pkg::CMD_RESET;
			wdata_reg      <= 8'h00;
			wdata_pend_reg <= 1'b0;
		end else begin
			if (byte_done && state_reg == gpx_pkg::ST_CMD) begin
				cmd_reg <= shift_reg[1:0];
			end
			if (byte_done && state_reg == gpx_pkg::ST_WDATA) begin
				wdata_reg      <= shift_reg;
				wdata_pend_reg <= 1'b1;
			end else begin
				wdata_pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			output_reg    <= gpx_pkg::OUTPUT_RESET;
			polarity_reg  <= gpx_pkg::POLARITY_RESET;
			direction_reg <= gpx_pkg::DIRECTION_RESET;
		end else if (wdata_pend_reg) begin
			case (cmd_reg)
				gpx_pkg::CMD_OUTPUT:    output_reg    <= wdata_reg;
				gpx_pkg::CMD_POLARITY:  polarity_reg  <= wdata_reg;
				gpx_pkg::CMD_DIRECTION: direction_reg <= wdata_reg;
				default:                output_reg    <= output_reg;
			endcase
		end
	end

	// ------------------------------------------------------------
	// port drivers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			port_pins_oe     <= 8'h00;
			port_pins_out    <= 8'h00;
			high_side_driver <= 8'h00;
			low_side_driver  <= 8'h00;
		end else begin
			port_pins_oe     <= ~direction_reg;
			port_pins_out    <= output_reg;
			high_side_driver <= ~direction_reg & output_reg;
			low_side_driver  <= ~direction_reg & ~output_reg;
		end
	end

	// ------------------------------------------------------------
	// direction aligned with synchronised pin levels
	// ------------------------------------------------------------
	logic [7:0] dir_d2_reg;
	logic [7:0] dir_d3_reg;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dir_d2_reg <= gpx_pkg::DIRECTION_RESET;
			dir_d3_reg <= gpx_pkg::DIRECTION_RESET;
		end else begin
			dir_d2_reg <= ~port_pins_oe;
			dir_d3_reg <= dir_d2_reg;
		end
	end

	// ------------------------------------------------------------
	// change alert
	// ------------------------------------------------------------
	logic [7:0] diff;
	logic       diff_any;
	logic [7:0] settle_cnt_reg;
	logic [2:0] snap_arm_reg;

	assign diff     = (pins_s ^ snapshot_reg) & direction_reg & dir_d3_reg;
	assign diff_any = |diff;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			snapshot_reg <= 8'h00;
			snap_arm_reg <= 3'h0;
		end else begin
			// reload until the synchroniser holds real pin levels
			snap_arm_reg <= {snap_arm_reg[1:0], 1'b1};
			if (read_clear || !snap_arm_reg[2]) begin
				snapshot_reg <= pins_s;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			settle_cnt_reg <= 8'h00;
		end else if (!diff_any || read_clear || !snap_arm_reg[2]) begin
			settle_cnt_reg <= 8'h00;
		end else if (settle_cnt_reg != 8'(gpx_pkg::ALERT_VALID_CYCLES)) begin
			settle_cnt_reg <= settle_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			alert_n_out <= 1'b0;
			alert_n_oe  <= 1'b0;
		end else begin
			alert_n_out <= 1'b0;
			alert_n_oe  <= diff_any && !read_clear &&
				settle_cnt_reg >= 8'(gpx_pkg::ALERT_VALID_CYCLES - 1);
		end
	end
endmodule // gpx_expander
`default_nettype wire

// *** hw/gpx_pkg.sv ***
`default_nettype none
package gpx_pkg;
	// ------------------------------------------------------------
	// bus address and command
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_FIXED      = 4'h4;
	localparam logic [1:0] CMD_INPUT       = 2'h0;
	localparam logic [1:0] CMD_OUTPUT      = 2'h1;
	localparam logic [1:0] CMD_POLARITY    = 2'h2;
	localparam logic [1:0] CMD_DIRECTION   = 2'h3;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OUTPUT_RESET    = 8'hFF;
	localparam logic [7:0] POLARITY_RESET  = 8'h00;
	localparam logic [7:0] DIRECTION_RESET = 8'hFF;
	localparam logic [1:0] CMD_RESET       = 2'h0;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ                  = 20000000;
	localparam int ALERT_VALID_DELAY_NS    = 4000;
	localparam int ALERT_VALID_CYCLES      = (ALERT_VALID_DELAY_NS * (CLK_HZ / 1000000)) / 1000;
	// ------------------------------------------------------------
	// bus states
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_ADDR  = 6'b000010,
		ST_CMD   = 6'b000100,
		ST_WDATA = 6'b001000,
		ST_RDATA = 6'b010000,
		ST_ACK   = 6'b100000
	} gpx_state_t;
endpackage
`default_nettype wire

// *** hw/gpx_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpx_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// ------------------------------------------------------------
	// two-stage synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // gpx_sync
`default_nettype wire

// *** verif/gpx_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpx_chk (
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       scl_in,
	input  wire logic       sda_out,
	input  wire logic       sda_oe,
	input  wire logic [7:0] port_pins_in,
	input  wire logic [7:0] port_pins_out,
	input  wire logic [7:0] port_pins_oe,
	input  wire logic [7:0] high_side_driver,
	input  wire logic [7:0] low_side_driver,
	input  wire logic       alert_n_out,
	input  wire logic       alert_n_oe
);
	logic [7:0] quiet_reg;
	logic [7:0] fall_cnt_reg;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ------------------------------------------------------------
	// cycles since the last pin change
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			quiet_reg <= 8'h00;
		else if ($changed(port_pins_in))
			quiet_reg <= 8'h00;
		else if (quiet_reg != 8'hFF)
			quiet_reg <= quiet_reg + 8'h01;
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			fall_cnt_reg <= 8'hFF;
		else if ($fell(scl_in))
			fall_cnt_reg <= 8'h00;
		else if (fall_cnt_reg != 8'hFF)
			fall_cnt_reg <= fall_cnt_reg + 8'h01;
	end
	sequence s_scl_high;
		scl_in [*2];
	endsequence
	a_drv_high: assert property (high_side_driver == (port_pins_oe & port_pins_out))
		else $error("high driver mismatch");
	a_drv_low: assert property (low_side_driver == (port_pins_oe & ~port_pins_out))
		else $error("low driver mismatch");
	a_input_off: assert property (((high_side_driver | low_side_driver) & ~port_pins_oe) == 8'h00)
		else $error("input pin driven");
	a_drain_low: assert property (!alert_n_out && !sda_out)
		else $error("open drain drives high");
	a_alert_wait: assert property ($rose(alert_n_oe) |-> quiet_reg >= gpx_pkg::ALERT_VALID_CYCLES)
		else $error("alert too early");
	a_sda_stable: assert property (s_scl_high |-> $stable(sda_oe))
		else $error("data moved in clock high");
	a_reset_dflt: assert property ($past(sys_rst) |-> port_pins_oe == 8'h00 && !alert_n_oe)
		else $error("reset state wrong");
	a_cfg_timely: assert property ($changed(port_pins_oe) |-> fall_cnt_reg < 8'h08)
		else $error("config change not tied to byte end");
endmodule // gpx_chk
bind gpx_expander gpx_chk u_chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .port_pins_in(port_pins_in), .port_pins_out(port_pins_out),
	.port_pins_oe(port_pins_oe), .high_side_driver(high_side_driver),
	.low_side_driver(low_side_driver), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe)
);
`default_nettype wire

// *** verif/gpx_expander_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpx_expander_test;
	logic            sys_clk;
	logic            sys_rst;
	logic [2:0]      strap;
	logic [7:0]      pins;
	logic [7:0]      q;
	logic            a;
	wire logic       scl;
	wire logic       sda_low;
	wire logic       sda_out;
	wire logic       sda_oe;
	wire logic [7:0] p_out;
	wire logic [7:0] p_oe;
	wire logic [7:0] hs;
	wire logic [7:0] ls;
	wire logic       al_oe;
	wire logic       sda = ~(sda_low | (sda_oe & ~sda_out));
	wire logic [7:0] lvl = (p_oe & p_out) | (~p_oe & pins);
	int n_mismatch = 0;
	int cmp_count = 0;
	gpx_expander u_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]),
		.addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
		.port_pins_in(lvl), .port_pins_out(p_out), .port_pins_oe(p_oe),
		.high_side_driver(hs), .low_side_driver(ls), .alert_n_out(), .alert_n_oe(al_oe)
	);
	gpx_host u_host (.sys_clk(sys_clk), .scl(scl), .sda_low(sda_low), .sda(sda));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] c, input logic [7:0] d);
		u_host.start();
		u_host.xfer({gpx_pkg::ADDR_FIXED, strap, 1'b0}, 1'b1, q, a);
		chk({7'h00, a}, 8'h00);
		u_host.xfer({6'h00, c}, 1'b1, q, a);
		u_host.xfer(8'h00, 1'b1, q, a);
		u_host.xfer(d, 1'b1, q, a);
		chk({7'h00, a}, 8'h00);
		u_host.stop();
	endtask
	task automatic rd(input logic [1:0] c, input logic [7:0] e);
		u_host.start();
		u_host.xfer({gpx_pkg::ADDR_FIXED, strap, 1'b0}, 1'b1, q, a);
		u_host.xfer({6'h00, c}, 1'b1, q, a);
		u_host.start();
		u_host.xfer({gpx_pkg::ADDR_FIXED, strap, 1'b1}, 1'b1, q, a);
		u_host.xfer(8'hFF, 1'b0, q, a);
		chk(q, e);
		u_host.xfer(8'hFF, 1'b1, q, a);
		chk(q, e);
		u_host.stop();
	endtask
	task automatic t_reset();
		chk(p_oe, 8'h00);
		chk(hs | ls, 8'h00);
		chk({7'h00, al_oe}, 8'h00);
		rd(gpx_pkg::CMD_OUTPUT, 8'hFF);
		rd(gpx_pkg::CMD_POLARITY, 8'h00);
		rd(gpx_pkg::CMD_DIRECTION, 8'hFF);
		$display("test reset done");
	endtask
	task automatic t_outputs();
		wr(gpx_pkg::CMD_DIRECTION, 8'h0F);
		wr(gpx_pkg::CMD_OUTPUT, 8'hA5);
		chk(p_oe, 8'hF0);
		chk(hs, 8'hA0);
		chk(ls, 8'h50);
		chk(p_out, 8'hA5);
		wr(gpx_pkg::CMD_INPUT, 8'h00);
		rd(gpx_pkg::CMD_OUTPUT, 8'hA5);
		wt(100);
		chk({7'h00, al_oe}, 8'h00);
		$display("test outputs done");
	endtask
	task automatic t_alert();
		pins[0] = 1'b0;
		wt(70);
		chk({7'h00, al_oe}, 8'h00);
		wt(20);
		chk({7'h00, al_oe}, 8'h01);
		pins[0] = 1'b1;
		wt(5);
		chk({7'h00, al_oe}, 8'h00);
		pins[1] = 1'b0;
		wt(100);
		u_host.start();
		u_host.xfer({gpx_pkg::ADDR_FIXED, strap ^ 3'h1, 1'b0}, 1'b1, q, a);
		chk({7'h00, a}, 8'h01);
		u_host.stop();
		chk({7'h00, al_oe}, 8'h01);
		wr(gpx_pkg::CMD_POLARITY, 8'h03);
		rd(gpx_pkg::CMD_INPUT, 8'hAE);
		chk({7'h00, al_oe}, 8'h00);
		pins[1] = 1'b1;
		wt(100);
		chk({7'h00, al_oe}, 8'h01);
		rd(gpx_pkg::CMD_INPUT, 8'hAC);
		wr(gpx_pkg::CMD_DIRECTION, 8'h4F);
		wt(100);
		chk({7'h00, al_oe}, 8'h01);
		$display("test alert done");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		strap = 3'h5;
		pins = 8'hFF;
		wt(10);
		sys_rst = 1'b0;
		wt(5);
		t_reset();
		t_outputs();
		t_alert();
		print_verdict();
	end
	initial begin
		wt(60000);
		n_mismatch++;
		print_verdict();
	end
endmodule // gpx_expander_test
`default_nettype wire

// *** verif/gpx_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpx_host (
	input  wire logic sys_clk,
	output var  logic scl,
	output var  logic sda_low,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic start();
		sda_low = 1'b0;
		wt(2);
		scl = 1'b1;
		wt(4);
		sda_low = 1'b1;
		wt(4);
		scl = 1'b0;
		wt(2);
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_low = ~b;
		wt(2);
		scl = 1'b1;
		wt(2);
		r = sda;
		wt(2);
		scl = 1'b0;
		wt(2);
	endtask
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(m, a);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		wt(2);
		scl = 1'b1;
		wt(4);
		sda_low = 1'b0;
		wt(4);
	endtask
endmodule // gpx_host
`default_nettype wire
